// file: itc_top.sv
// Interrupt nodes, event transfer engine, external request router and trap unit behind AXI4-Lite.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module itc_top
  import itc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NDED-1:0]   src_req,
  input  wire logic [NSH*NSHSRC-1:0] shared_req,
  input  wire logic [NRTR-1:0]   router_pin,
  input  wire logic [NSRP-1:0]   service_request_pin,
  input  wire logic [NHWTRAP-1:0] hw_trap,
  input  wire logic              trap_done,
  input  wire logic [3:0]        cpu_prio,
  input  wire logic              sw_trap,
  input  wire logic [7:0]        sw_trap_num,
  output logic                   branch,
  output logic [7:0]             branch_vec,
  output logic                   branch_is_trap,
  output logic                   cpu_steal,
  output logic                   xfer_valid,
  output logic [23:0]            xfer_src,
  output logic [23:0]            xfer_dst,
  output logic                   xfer_word
);

  // ==========================================================================
  // State and combinational helpers
  itc_state_t        s;
  itc_state_t        next_s;
  logic [NODES-1:0]  nev;
  logic [NRTR-1:0]   rtr_ev;
  logic [NRTR-1:0]   rtr_out;
  logic [NTRAP-1:0]  tev;
  logic [6:0]        best;
  logic [3:0]        bprio;
  logic              found;
  logic              grant;
  logic [2:0]        gch;
  logic              xe_go;
  logic              trap_take;
  logic [2:0]        tidx;
  logic              wr_go;
  logic [31:0]       wd;

  // Address decode shared by the read and write paths.
  function automatic itc_sel_t dec(input logic [11:0] a);
    itc_sel_t r;
    r = SEL_NONE;
    if (a < A_NODE_END) begin
      r = SEL_NODE;
    end else if (a[11:4] == A_SSEL[11:4]) begin
      r = SEL_SSEL;
    end else if (a >= A_CH && a < A_CH_END) begin
      r = SEL_CH;
    end else if (a[11:2] == A_TRAPF[11:2]) begin
      r = SEL_TRAPF;
    end else if (a[11:2] == A_PINCFG[11:2]) begin
      r = SEL_PINCFG;
    end else if (a[11:2] == A_SYS[11:2]) begin
      r = SEL_SYS;
    end else if (a[11:2] == A_STAT[11:2]) begin
      r = SEL_STAT;
    end else if (a[11:4] == A_ERUI[11:4]) begin
      r = SEL_ERUI;
    end else if (a[11:4] == A_ERUO[11:4]) begin
      r = SEL_ERUO;
    end
    return r;
  endfunction

  // Register read mux; unused bits read as zero.
  function automatic logic [31:0] rd_reg(input logic [11:0] a);
    logic [31:0] r;
    logic [11:0] off;
    r   = 32'h0000_0000;
    off = a - A_CH;
    unique case (dec(a))
      SEL_NODE: r = {20'h00000, s.ctl[a[8:2]]};
      SEL_SSEL: r = {30'h0, s.ssel[a[3:2]]};
      SEL_CH: begin
        unique case (off[3:2])
          2'h0: r = {8'h00, s.sptr[off[6:4]]};
          2'h1: r = {8'h00, s.dptr[off[6:4]]};
          2'h2: r = {24'h000000, s.cnt[off[6:4]]};
          2'h3: r = {28'h0000000, s.ccfg[off[6:4]]};
        endcase
      end
      SEL_TRAPF:  r = {24'h000000, s.trap_flags};
      SEL_PINCFG: r = {26'h0, s.pin_cfg};
      SEL_SYS:  r = {31'h0, s.jc};
      SEL_STAT: r = {23'h0, s.gnode[3:0], s.trap_active, s.trap_lvl, s.lat_busy};
      SEL_ERUI: r = {30'h0, s.erui[a[3:2]]};
      SEL_ERUO: r = {22'h0, s.eruo[a[3:2]]};
      SEL_NONE: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Next-state logic for the whole block.
  always_comb begin
    logic [11:0] woff;
    logic [23:0] inc;
    woff   = s_axi_awaddr - A_CH;
    inc    = 24'h000001;
    next_s = s;
    next_s.branch     = 1'b0;
    next_s.cpu_steal  = 1'b0;
    next_s.xfer_valid = 1'b0;

    // Pins pass two flops; the third stage only serves edge detection.
    next_s.rtr_s1 = router_pin;
    next_s.rtr_s2 = s.rtr_s1;
    next_s.rtr_s3 = s.rtr_s2;
    next_s.srp_s1 = service_request_pin;
    next_s.srp_s2 = s.srp_s1;
    next_s.srp_s3 = s.srp_s2;

    // Router trigger stages, then matrix and gating per output.
    for (int i = 0; i < NRTR; i++) begin
      rtr_ev[i] = (s.rtr_s2[i] & ~s.rtr_s3[i] & s.erui[i][0]) |
                  (~s.rtr_s2[i] & s.rtr_s3[i] & s.erui[i][1]);
    end
    for (int o = 0; o < NRTR; o++) begin
      unique case (s.eruo[o][9:8])
        G_BLOCK: rtr_out[o] = 1'b0;
        G_PASS:  rtr_out[o] = |(rtr_ev & s.eruo[o][3:0]);
        G_MATCH: rtr_out[o] = (|(rtr_ev & s.eruo[o][3:0])) &
                              (((s.rtr_s2 ^ s.eruo[o][7:4]) & s.eruo[o][3:0]) == 4'h0);
        G_MISS:  rtr_out[o] = (|(rtr_ev & s.eruo[o][3:0])) &
                              (((s.rtr_s2 ^ s.eruo[o][7:4]) & s.eruo[o][3:0]) != 4'h0);
      endcase
    end

    // Hardware events per node: dedicated, shared through the selectors, router outputs.
    for (int k = 0; k < NDED; k++) begin
      nev[k] = src_req[k];
    end
    for (int k = 0; k < NSH; k++) begin
      nev[NDED+k] = shared_req[k*NSHSRC + int'(s.ssel[k])];
    end
    for (int o = 0; o < NRTR; o++) begin
      nev[RTR_NODE0+o] = nev[RTR_NODE0+o] | rtr_out[o];
    end

    // Service request pins raise the two system request traps on a rising edge.
    tev = {hw_trap, 2'b00};
    for (int p = 0; p < NSRP; p++) begin
      tev[T_SYSREQ0] = tev[T_SYSREQ0] | (s.srp_s2[p] & ~s.srp_s3[p] & s.pin_cfg[2*p]);
      tev[T_SYSREQ1] = tev[T_SYSREQ1] | (s.srp_s2[p] & ~s.srp_s3[p] & s.pin_cfg[2*p+1]);
    end
    tidx = 3'h0;
    for (int t = 0; t < NTRAP; t++) begin
      if (tev[t]) begin
        tidx = 3'(t);
      end
    end
    trap_take = (|tev) && (!s.trap_active || tidx > s.trap_lvl);

    // Ties go to the lowest node index because only a strictly higher level replaces.
    best  = 7'h00;
    bprio = 4'h0;
    found = 1'b0;
    for (int k = 0; k < NODES; k++) begin
      if (s.ctl[k][F_REQ] && s.ctl[k][F_EN] && (!found || s.ctl[k][F_PRIO+3:F_PRIO] > bprio)) begin
        best  = 7'(k);
        bprio = s.ctl[k][F_PRIO+3:F_PRIO];
        found = 1'b1;
      end
    end
    grant = found && (bprio > cpu_prio) && !s.lat_busy && !s.trap_active;
    gch   = s.ctl[best][F_CHS+2:F_CHS];
    xe_go = grant && s.ctl[best][F_XE] && (s.cnt[gch] != 8'h00 || s.ccfg[gch][C_CONT]);
    if (s.ccfg[gch][C_WORD]) begin
      inc = 24'h000002;
    end

    // Service start: the engine moves one unit in one stolen cycle, otherwise the latency timer runs.
    if (s.lat_busy) begin
      if (s.lat_cnt != 4'h0) begin
        next_s.lat_cnt = s.lat_cnt - 4'h1;
      end else if (!trap_take && !s.trap_active && !sw_trap) begin
        next_s.branch         = 1'b1;
        next_s.branch_vec     = 8'(NODE_VEC0 + {1'b0, s.gnode});
        next_s.branch_is_trap = 1'b0;
        next_s.lat_busy       = 1'b0;
      end
    end else if (grant) begin
      next_s.ctl[best][F_REQ] = 1'b0;
      next_s.gnode            = best;
      if (xe_go) begin
        next_s.xch        = gch;
        next_s.cpu_steal  = 1'b1;
        next_s.xfer_valid = 1'b1;
        next_s.xfer_src   = s.sptr[gch];
        next_s.xfer_dst   = s.dptr[gch];
        next_s.xfer_word  = s.ccfg[gch][C_WORD];
        if (s.ccfg[gch][C_INCS]) begin
          next_s.sptr[gch] = s.sptr[gch] + inc;
        end
        if (s.ccfg[gch][C_INCD]) begin
          next_s.dptr[gch] = s.dptr[gch] + inc;
        end
        if (!s.ccfg[gch][C_CONT]) begin
          next_s.cnt[gch] = s.cnt[gch] - 8'h01;
        end
      end else begin
        next_s.lat_busy = 1'b1;
        next_s.lat_cnt  = s.jc ? LAT_LD_JC : LAT_LD_NJC;
      end
    end

    // Traps branch at once and outrank a software trap in the same cycle.
    if (trap_take) begin
      next_s.branch         = 1'b1;
      next_s.branch_vec     = 8'(TRAP_VEC0 + {5'h00, tidx});
      next_s.branch_is_trap = 1'b1;
      next_s.trap_active    = 1'b1;
      next_s.trap_lvl       = tidx;
    end else begin
      if (trap_done) begin
        next_s.trap_active = 1'b0;
      end
      if (sw_trap) begin
        next_s.branch         = 1'b1;
        next_s.branch_vec     = sw_trap_num;
        next_s.branch_is_trap = 1'b1;
      end
    end

    // Write channel: address and data are taken together, the response follows.
    wr_go = s.awready;
    wd    = rd_reg(s_axi_awaddr);
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b]) begin
        wd[8*b +: 8] = s_axi_wdata[8*b +: 8];
      end
    end
    if (wr_go) begin
      next_s.awready = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = (dec(s_axi_awaddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (dec(s_axi_awaddr))
        SEL_NODE: next_s.ctl[s_axi_awaddr[8:2]] = wd[11:0];
        SEL_SSEL: next_s.ssel[s_axi_awaddr[3:2]] = wd[1:0];
        SEL_CH: begin
          unique case (woff[3:2])
            2'h0: next_s.sptr[woff[6:4]] = wd[23:0];
            2'h1: next_s.dptr[woff[6:4]] = wd[23:0];
            2'h2: next_s.cnt[woff[6:4]]  = wd[7:0];
            2'h3: next_s.ccfg[woff[6:4]] = wd[3:0];
          endcase
        end
        SEL_TRAPF:  next_s.trap_flags = s.trap_flags & ~(s_axi_wdata[7:0] & {8{s_axi_wstrb[0]}});
        SEL_PINCFG: next_s.pin_cfg = wd[5:0];
        SEL_SYS:  next_s.jc = wd[0];
        SEL_ERUI: next_s.erui[s_axi_awaddr[3:2]] = wd[1:0];
        SEL_ERUO: next_s.eruo[s_axi_awaddr[3:2]] = wd[9:0];
        SEL_STAT, SEL_NONE: next_s.bresp = next_s.bresp;
      endcase
    end else if (!s.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      next_s.awready = 1'b1;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel: one cycle of arready, then the data.
    if (s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = rd_reg(s_axi_araddr);
      next_s.rresp   = (dec(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (!s.rvalid && s_axi_arvalid) begin
      next_s.arready = 1'b1;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Hardware sets come last so that an event beats a clear in the same cycle.
    for (int k = 0; k < NODES; k++) begin
      next_s.ctl[k][F_REQ] = next_s.ctl[k][F_REQ] | nev[k];
    end
    next_s.trap_flags = next_s.trap_flags | tev;
  end

  // ==========================================================================
  // The single state register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from the state register.
  assign s_axi_awready  = s.awready;
  assign s_axi_wready   = s.awready;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_arready  = s.arready;
  assign s_axi_rvalid   = s.rvalid;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = s.rresp;
  assign branch         = s.branch;
  assign branch_vec     = s.branch_vec;
  assign branch_is_trap = s.branch_is_trap;
  assign cpu_steal      = s.cpu_steal;
  assign xfer_valid     = s.xfer_valid;
  assign xfer_src       = s.xfer_src;
  assign xfer_dst       = s.xfer_dst;
  assign xfer_word      = s.xfer_word;

  // ==========================================================================
  // Assertions
  property p_steal_one;
    @(posedge ref_clk) disable iff (!rst_n) cpu_steal |-> ($past(xe_go) && xfer_valid);
  endproperty
  a_steal_one: assert property (p_steal_one) else $error("stolen cycle without an engine grant");

  property p_xfer_with_steal;
    @(posedge ref_clk) disable iff (!rst_n) xe_go |=> (xfer_valid && cpu_steal && !s.lat_busy);
  endproperty
  a_xfer_with_steal: assert property (p_xfer_with_steal) else $error("transfer without stolen cycle");

  property p_lat_exact;
    @(posedge ref_clk) disable iff (!rst_n)
      ($rose(s.lat_busy) && s.lat_cnt == LAT_LD_JC) ##1 (!s.trap_active && !trap_take && !sw_trap) [*4]
      |=> (branch && !branch_is_trap);
  endproperty
  a_lat_exact: assert property (p_lat_exact) else $error("interrupt branch not at shortest latency");

  property p_cnt_dec;
    @(posedge ref_clk) disable iff (!rst_n)
      (xe_go && !s.ccfg[gch][C_CONT] && !wr_go) |=> (s.cnt[s.xch] == $past(s.cnt[gch]) - 8'h01);
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("transfer counter not decremented");

  property p_zero_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (grant && s.ctl[best][F_XE] && s.cnt[gch] == 8'h00 && !s.ccfg[gch][C_CONT]) |=> (s.lat_busy && !xfer_valid);
  endproperty
  a_zero_irq: assert property (p_zero_irq) else $error("empty channel did not fall back to interrupt");

  property p_trap_now;
    @(posedge ref_clk) disable iff (!rst_n)
      trap_take |=> (branch && branch_is_trap && s.trap_active && s.trap_flags[s.trap_lvl]);
  endproperty
  a_trap_now: assert property (p_trap_now) else $error("trap not taken at once");

  property p_trap_blocks;
    @(posedge ref_clk) disable iff (!rst_n) s.trap_active |-> !(branch && !branch_is_trap);
  endproperty
  a_trap_blocks: assert property (p_trap_blocks) else $error("interrupt branch during trap service");

  property p_trap_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.trap_active && (|tev) && tidx <= s.trap_lvl && !trap_done) |=> (s.trap_lvl == $past(s.trap_lvl));
  endproperty
  a_trap_keep: assert property (p_trap_keep) else $error("lower trap preempted running trap");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (!rst_n) (grant && !nev[best] && !wr_go) |=> !s.ctl[s.gnode][F_REQ];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("request flag kept after acceptance");

endmodule

// file: itc_pkg.sv
// Shared constants, register map and state type of the interrupt, event transfer and trap block.
package itc_pkg;

  // ==========================================================================
  // Sizes
  localparam int NODES     = 96;
  localparam int NSH       = 4;
  localparam int NDED      = NODES - NSH;
  localparam int NSHSRC    = 4;
  localparam int NCH       = 8;
  localparam int NRTR      = 4;
  localparam int NSRP      = 3;
  localparam int NHWTRAP   = 6;
  localparam int NTRAP     = NHWTRAP + 2;
  localparam int RTR_NODE0 = 0;

  // ==========================================================================
  // Register byte addresses
  localparam logic [11:0] A_NODE     = 12'h000;
  localparam logic [11:0] A_NODE_END = 12'h180;
  localparam logic [11:0] A_SSEL     = 12'h200;
  localparam logic [11:0] A_CH       = 12'h240;
  localparam logic [11:0] A_CH_END   = 12'h2c0;
  localparam logic [11:0] A_TRAPF    = 12'h300;
  localparam logic [11:0] A_PINCFG   = 12'h304;
  localparam logic [11:0] A_SYS      = 12'h308;
  localparam logic [11:0] A_STAT     = 12'h30c;
  localparam logic [11:0] A_ERUI     = 12'h310;
  localparam logic [11:0] A_ERUO     = 12'h320;

  // ==========================================================================
  // Node control fields
  localparam int F_PRIO = 0;
  localparam int F_EN   = 6;
  localparam int F_REQ  = 7;
  localparam int F_XE   = 8;
  localparam int F_CHS  = 9;

  // Channel configuration fields
  localparam int C_WORD = 0;
  localparam int C_INCS = 1;
  localparam int C_INCD = 2;
  localparam int C_CONT = 3;

  // Output gating modes
  localparam logic [1:0] G_BLOCK = 2'h0;
  localparam logic [1:0] G_PASS  = 2'h1;
  localparam logic [1:0] G_MATCH = 2'h2;
  localparam logic [1:0] G_MISS  = 2'h3;

  // ==========================================================================
  // Vectors, trap indices, latency and bus answers
  localparam logic [7:0]  TRAP_VEC0 = 8'h00;
  localparam logic [7:0]  NODE_VEC0 = 8'h08;
  localparam int          T_SYSREQ0 = 0;
  localparam int          T_SYSREQ1 = 1;
  localparam int          LAT_JC    = 7;
  localparam int          LAT_NJC   = 11;
  // The event cycle, the grant cycle and the branch cycle itself lie outside the timer.
  localparam logic [3:0]  LAT_LD_JC  = 4'(LAT_JC - 3);
  localparam logic [3:0]  LAT_LD_NJC = 4'(LAT_NJC - 3);
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_NODE, SEL_SSEL, SEL_CH, SEL_TRAPF, SEL_PINCFG, SEL_SYS, SEL_STAT, SEL_ERUI, SEL_ERUO
  } itc_sel_t;

  typedef struct packed {
    logic [NODES-1:0][11:0] ctl;
    logic [NSH-1:0][1:0]    ssel;
    logic [NCH-1:0][23:0]   sptr;
    logic [NCH-1:0][23:0]   dptr;
    logic [NCH-1:0][7:0]    cnt;
    logic [NCH-1:0][3:0]    ccfg;
    logic [NTRAP-1:0]       trap_flags;
    logic [2*NSRP-1:0]      pin_cfg;
    logic                   jc;
    logic [NRTR-1:0][1:0]   erui;
    logic [NRTR-1:0][9:0]   eruo;
    logic [NRTR-1:0]        rtr_s1;
    logic [NRTR-1:0]        rtr_s2;
    logic [NRTR-1:0]        rtr_s3;
    logic [NSRP-1:0]        srp_s1;
    logic [NSRP-1:0]        srp_s2;
    logic [NSRP-1:0]        srp_s3;
    logic                   lat_busy;
    logic [3:0]             lat_cnt;
    logic [6:0]             gnode;
    logic [2:0]             xch;
    logic                   trap_active;
    logic [2:0]             trap_lvl;
    logic                   awready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic                   branch;
    logic [7:0]             branch_vec;
    logic                   branch_is_trap;
    logic                   cpu_steal;
    logic                   xfer_valid;
    logic [23:0]            xfer_src;
    logic [23:0]            xfer_dst;
    logic                   xfer_word;
  } itc_state_t;

endpackage

// file: itc_cpu_model.sv
// Behavioural CPU core and memory side that face the interrupt, transfer and trap block.
`timescale 1ns/10ps
module itc_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       branch,
  input  wire logic       branch_is_trap,
  input  wire logic       xfer_valid,
  output logic            trap_done,
  output logic [7:0]      steal_cnt
);
  logic [2:0] wait_cnt;

  // ==========================================================================
  // Trap handler
  // A trap handler returns a few cycles after its branch, so requests that arrive
  // meanwhile meet an active trap. Every stolen cycle is counted for the bench.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt  <= 3'h0;
      trap_done <= 1'b0;
      steal_cnt <= 8'h00;
    end else begin
      trap_done <= (wait_cnt == 3'h1);
      if (branch && branch_is_trap) begin
        wait_cnt <= 3'h4;
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
      if (xfer_valid) begin
        steal_cnt <= steal_cnt + 8'h01;
      end
    end
  end
endmodule

// file: interrupt_event_trap_system_bench.sv
// Self-checking bench for the interrupt, event transfer and trap block.
`timescale 1ns/10ps
module interrupt_event_trap_system_bench;
  import itc_pkg::*;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [11:0]     awaddr = 12'h000;
  logic [11:0]     araddr = 12'h000;
  logic [31:0]     wdata = 32'h0;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [1:0]      bresp, rresp;
  logic [31:0]     rdata;
  logic [NDED-1:0] src_req = '0;
  logic [15:0]     sh_req = 16'h0000;
  logic [3:0]      rpin = 4'h0, cprio = 4'h0;
  logic [2:0]      spin = 3'h0;
  logic [5:0]      hw_trap = 6'h00;
  logic            sw_trap = 1'b0;
  logic [7:0]      sw_num = 8'h00;
  logic            branch, btrap, steal, xv, xword, trap_done;
  logic [7:0]      bvec, steal_cnt;
  logic [23:0]     xsrc, xdst;
  int              num_errors = 0, compares = 0, cyc = 0, n;

  itc_top i_itc_top (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_req(src_req),
    .shared_req(sh_req), .router_pin(rpin), .service_request_pin(spin), .hw_trap(hw_trap),
    .trap_done(trap_done), .cpu_prio(cprio), .sw_trap(sw_trap), .sw_trap_num(sw_num), .branch(branch),
    .branch_vec(bvec), .branch_is_trap(btrap), .cpu_steal(steal), .xfer_valid(xv), .xfer_src(xsrc),
    .xfer_dst(xdst), .xfer_word(xword));
  itc_cpu_model i_itc_cpu_model (.ref_clk(ref_clk), .rst_n(rst_n), .branch(branch),
    .branch_is_trap(btrap), .xfer_valid(xv), .trap_done(trap_done), .steal_cnt(steal_cnt));

  // ==========================================================================
  // Clock, pulse release and hang guard
  always #25 ref_clk = ~ref_clk;
  // Pulses are dropped one edge after they rise; only a raised pulse is touched.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (src_req != '0) src_req <= '0;
    if (sh_req != 16'h0000) sh_req <= 16'h0000;
    if (hw_trap != 6'h00) hw_trap <= 6'h00;
    if (sw_trap) sw_trap <= 1'b0;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address and data go up together and are released at the edge that takes them.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge ref_clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge ref_clk);
    bready <= 1'b0;
    chk(bresp, resp);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge ref_clk);
    rready <= 1'b0;
    chk(rdata, d);
    chk(rresp, resp);
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    src_req[i] <= 1'b1;
  endtask
  // Counts cycles from the event cycle (1) up to the cycle that shows the output.
  task automatic wait_ev(input bit xf);
    n = 0;
    repeat (40) begin
      @(negedge ref_clk);
      n++;
      if ((xf ? xv : branch) === 1'b1) break;
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    wr(12'h014, 32'h45, RESP_OKAY);
    rc(12'h014, 32'h45, RESP_OKAY);
    rc(12'hffc, 32'h0, RESP_SLVERR);
    wr(12'hffc, 32'h1, RESP_SLVERR);
    wr(12'h014, 32'h0, RESP_OKAY);
  endtask
  task automatic t_engine;
    wr(12'h000, 32'h141, RESP_OKAY);
    wr(12'h240, 32'h100, RESP_OKAY);
    wr(12'h244, 32'h200, RESP_OKAY);
    wr(12'h248, 32'h2, RESP_OKAY);
    wr(12'h24c, 32'h7, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      pulse(0);
      wait_ev(1'b1);
      chk(32'(n), 32'd3);
      chk(32'(steal), 32'h1);
      chk(32'(xsrc), 32'h100 + 32'(2 * i));
      chk(32'(xdst), 32'h200 + 32'(2 * i));
      chk(32'(xword), 32'h1);
    end
    rc(12'h248, 32'h0, RESP_OKAY);
    pulse(0);
    wait_ev(1'b0);
    chk(32'(n), 32'(LAT_NJC + 1));
    chk(32'(bvec), 32'(NODE_VEC0));
    chk(32'(steal_cnt), 32'h2);
    wr(12'h248, 32'h1, RESP_OKAY);
    wr(12'h24c, 32'hb, RESP_OKAY);
    pulse(0);
    wait_ev(1'b1);
    chk(32'(xdst), 32'h204);
    rc(12'h248, 32'h1, RESP_OKAY);
  endtask
  task automatic t_irq;
    wr(A_SYS, 32'h1, RESP_OKAY);
    wr(12'h024, 32'h43, RESP_OKAY);
    pulse(9);
    wait_ev(1'b0);
    chk(32'(n), 32'(LAT_JC + 1));
    chk(32'(bvec), 32'h11);
    chk(32'(btrap), 32'h0);
    wr(12'h024, 32'hc3, RESP_OKAY);
    wait_ev(1'b0);
    chk(32'(bvec), 32'h11);
    rc(12'h024, 32'h43, RESP_OKAY);
  endtask
  task automatic t_trap;
    @(posedge ref_clk);
    hw_trap[1] <= 1'b1;
    wait_ev(1'b0);
    chk(32'(n), 32'd2);
    chk(32'(bvec), 32'(TRAP_VEC0) + 32'd3);
    chk(32'(btrap), 32'h1);
    pulse(9);
    wait_ev(1'b0);
    chk(32'(n > LAT_JC + 1), 32'h1);
    rc(A_TRAPF, 32'h08, RESP_OKAY);
    wr(A_TRAPF, 32'h08, RESP_OKAY);
    rc(A_TRAPF, 32'h00, RESP_OKAY);
    @(posedge ref_clk);
    sw_trap <= 1'b1;
    sw_num <= 8'h2a;
    wait_ev(1'b0);
    chk(32'(n), 32'd2);
    chk(32'(bvec), 32'h2a);
    chk(32'(btrap), 32'h1);
  endtask
  // A high CPU level parks the shared node's flag so that it can be read back.
  task automatic t_route;
    @(posedge ref_clk);
    cprio <= 4'hf;
    wr(A_SSEL, 32'h2, RESP_OKAY);
    wr(12'h170, 32'h44, RESP_OKAY);
    @(posedge ref_clk);
    sh_req[1] <= 1'b1;
    rc(12'h170, 32'h44, RESP_OKAY);
    @(posedge ref_clk);
    sh_req[2] <= 1'b1;
    rc(12'h170, 32'hc4, RESP_OKAY);
    @(posedge ref_clk);
    cprio <= 4'h0;
    wait_ev(1'b0);
    chk(32'(bvec), 32'(NODE_VEC0) + 32'd92);
    wr(A_ERUI, 32'h1, RESP_OKAY);
    wr(A_ERUO + 12'h004, 32'h211, RESP_OKAY);
    wr(12'h004, 32'h45, RESP_OKAY);
    @(posedge ref_clk);
    rpin[0] <= 1'b1;
    wait_ev(1'b0);
    // The two synchroniser stages add two cycles to the shortest latency.
    chk(32'(n), 32'(LAT_JC + 3));
    chk(32'(bvec), 32'(NODE_VEC0) + 32'd1);
    @(posedge ref_clk);
    rpin[0] <= 1'b0;
    wait_ev(1'b0);
    chk(32'(n), 32'd40);
    wr(A_PINCFG, 32'h2, RESP_OKAY);
    @(posedge ref_clk);
    spin[0] <= 1'b1;
    wait_ev(1'b0);
    chk(32'(n), 32'd4);
    chk(32'(bvec), 32'(TRAP_VEC0) + 32'(T_SYSREQ1));
    chk(32'(btrap), 32'h1);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_engine();
    t_irq();
    t_trap();
    t_route();
    test_done();
  end
endmodule
